// >>> logic/iva_fetch_gate.v
`timescale 1ns/1ns
`include "iva_regs.vh"

// ***********************************************************************
// fetch gate: zero bytes beyond the implemented program memory
// ***********************************************************************
module iva_fetch_gate #(
    parameter MEM_BYTES = 2048
) (
    input  wire [14:0] fetch_addr,
    input  wire [7:0]  fetch_raw,
    output wire [7:0]  fetch_data,
    output wire        is_trap
);
    localparam [31:0] LIMIT = MEM_BYTES;

    // unimplemented space reads as zero, which decodes as the trap
    assign fetch_data = ({17'h0_0000, fetch_addr} < LIMIT) ? fetch_raw
                        : `IVA_TRAP_OPCODE;
    assign is_trap    = (fetch_data == `IVA_TRAP_OPCODE);
endmodule // iva_fetch_gate

// >>> logic/iva_regs.vh
`ifndef IVA_REGS_VH
`define IVA_REGS_VH

// register byte offsets on the bus
`define IVA_OFS_CTRL        8'h00
`define IVA_OFS_SRC_EN      8'h04
`define IVA_OFS_WAKE_EN     8'h08
`define IVA_OFS_WAKE_EDGE   8'h0C
`define IVA_OFS_WAKE_PEND   8'h10
`define IVA_OFS_STATUS      8'h14

// control register fields
`define IVA_CTRL_GIE        0
`define IVA_CTRL_PORTL_EN   1
`define IVA_CTRL_RESET      2'b01

// status register fields
`define IVA_STAT_OFS_LSB    0
`define IVA_STAT_OFS_MSB    7
`define IVA_STAT_IRQ        8
`define IVA_STAT_BUSY       9

// arbitration ranks, index 15 is the highest
`define IVA_RANK_TRAP       15
`define IVA_RANK_SRC_TOP    13
`define IVA_RANK_PORTL      1
`define IVA_RANK_DEFAULT    4'h0

// opcodes, offsets and fixed addresses
`define IVA_TRAP_OPCODE     8'h00
`define IVA_VEC_BASE        8'hE0
`define IVA_ENTRY_ADDR      15'h00FF
`define IVA_STACK_LIMIT     8'h6F
`define IVA_UNDERFLOW_PC    15'h7FFF

// htrans nonseq bit and okay response
`define IVA_HTRANS_ACTIVE   1
`define IVA_HRESP_OKAY      1'b0

`endif

// >>> logic/iva_top.v
// Notes on behaviour
// - dispatch yields even offset E0..FE by rank
// - trap active gives offset FE always
// - external-class source gives FA, lower ranks descend
// - nothing active gives default offset E0
// - offset replaces only program counter low byte
// - vector fetched from table loads program counter
// - vector is two bytes, high first, 15 bits
// - trap pending set on trap, cleared by reset
// - trap pending flag has no software path
// - pending-clear instruction or reset clears trap pending
// - zero opcode on a valid fetch raises trap
// - fetches beyond memory return zero bytes
// - stack underflow past 06F loads 7FFF
// - trap taken at once, highest priority
// - trap keeps global enable, blocks maskable interrupts
// - only another trap preempts trap routine
// - trap pushes address of the trap opcode
// - eight port L edge inputs, individual enables
// - per-pin edge select rising or falling
// - detected edge latched in wake pending bit
// - port L request needs group and global enable
// - wake resumes inline or through service routine
// - maskable never preempts a running routine
// - interrupt return sets enable, loads popped address
// - fixed rank: trap, bus sources, down to port L
`timescale 1ns/1ns
`include "iva_regs.vh"

module iva_top #(
    parameter MEM_BYTES = 2048,
    parameter N_SRC     = 9,
    parameter N_WAKE    = 8
) (
    input  wire              ref_clk,
    input  wire              rst,
    input  wire              hsel,
    input  wire [7:0]        haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire              hready,
    input  wire [31:0]       hwdata,
    output reg  [31:0]       hrdata,
    output reg               hreadyout,
    output reg               hresp,
    input  wire              vis_exec,
    input  wire [14:0]       vis_pc,
    input  wire              clear_trap_pending_instr_exec,
    input  wire              ret_exec,
    input  wire              ret_is_return_from_irq_instr,
    input  wire [14:0]       ret_addr,
    input  wire [7:0]        stack_ptr,
    input  wire              instr_boundary,
    input  wire [14:0]       next_pc,
    input  wire              fetch_valid,
    input  wire [14:0]       fetch_addr,
    input  wire [7:0]        fetch_raw,
    input  wire [7:0]        vec_rdata,
    input  wire [N_SRC-1:0]  src_pend,
    input  wire [N_WAKE-1:0] portl_in,
    input  wire              low_power,
    output reg  [7:0]        instr_out,
    output reg               instr_valid,
    output reg               pc_load,
    output reg  [14:0]       pc_value,
    output reg               push_req,
    output reg  [14:0]       push_addr,
    output reg               vec_rd,
    output reg  [14:0]       vec_addr,
    output reg               irq_req,
    output reg               wake_req
);
    // one-hot dispatch states
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_HI   = 4'b0010;
    localparam [3:0] S_LO   = 4'b0100;
    localparam [3:0] S_DONE = 4'b1000;

    // ***********************************************************************
    // state
    // ***********************************************************************
    reg [1:0]        ctrl_reg;
    reg [N_SRC-1:0]  src_en_reg;
    reg [N_WAKE-1:0] wake_en_reg;
    reg [N_WAKE-1:0] wake_edge_reg;
    reg [N_WAKE-1:0] wake_pend_reg;
    reg [N_WAKE-1:0] portl_prev_reg;
    reg              trap_pending_flag;
    reg [7:0]        last_ofs_reg;
    reg [3:0]        state_reg;
    reg [6:0]        vec_hi_reg;
    reg              wr_pend_reg;
    reg [7:0]        wr_addr_reg;

    wire [7:0] fetch_data;
    wire       fetch_is_trap;

    // ***********************************************************************
    // zero-fill of unimplemented program memory
    // ***********************************************************************
    iva_fetch_gate #(
        .MEM_BYTES (MEM_BYTES)
    ) u_gate (
        .fetch_addr (fetch_addr),
        .fetch_raw  (fetch_raw),
        .fetch_data (fetch_data),
        .is_trap    (fetch_is_trap)
    );

    wire trap_take = fetch_valid & fetch_is_trap;

    // ***********************************************************************
    // port L edge detection
    // ***********************************************************************
    wire [N_WAKE-1:0] wake_hit;
    genvar g;
    generate
        for (g = 0; g < N_WAKE; g = g + 1) begin : g_edge
            // edge select 1 picks falling, 0 picks rising
            assign wake_hit[g] = wake_edge_reg[g] ?
                (portl_prev_reg[g] & ~portl_in[g]) :
                (~portl_prev_reg[g] & portl_in[g]);
        end
    endgenerate

    // ***********************************************************************
    // active vector and priority encoder
    // ***********************************************************************
    wire global_irq_enable      = ctrl_reg[`IVA_CTRL_GIE];
    wire portl_en = ctrl_reg[`IVA_CTRL_PORTL_EN];
    wire portl_active = portl_en & (|(wake_pend_reg & wake_en_reg));

    reg  [15:0] active;
    reg  [3:0]  win_idx;
    reg  [7:0]  win_ofs;
    integer     i;

    // ranks 14 and 4..2 are unused slots and never become active
    always @* begin
        active = 16'h0000;
        active[`IVA_RANK_TRAP] = trap_pending_flag;
        for (i = 0; i < N_SRC; i = i + 1) begin
            active[`IVA_RANK_SRC_TOP - i] = src_pend[i] & src_en_reg[i];
        end
        active[`IVA_RANK_PORTL] = portl_active;
        win_idx = `IVA_RANK_DEFAULT;
        for (i = 0; i < 16; i = i + 1) begin
            if (active[i]) begin
                win_idx = i[3:0];
            end
        end
        win_ofs = `IVA_VEC_BASE + {3'b000, win_idx, 1'b0};
    end

    // maskable sources wait while the trap flag is set or gie is low
    wire maskable_any = |active[`IVA_RANK_SRC_TOP:`IVA_RANK_PORTL];
    wire maskable_ok  = maskable_any & global_irq_enable & ~trap_pending_flag;
    wire mask_take    = instr_boundary & maskable_ok & ~trap_take
                        & state_reg[0];

    // ***********************************************************************
    // bus slave: zero wait, always okay
    // ***********************************************************************
    wire addr_phase = hsel & hready & htrans[`IVA_HTRANS_ACTIVE];
    wire do_write   = wr_pend_reg;
    wire wr_ctrl    = do_write & (wr_addr_reg == `IVA_OFS_CTRL);
    wire wr_pend_w1c = do_write & (wr_addr_reg == `IVA_OFS_WAKE_PEND);

    reg [31:0] rd_mux;

    // trap pending flag is deliberately absent from this map
    always @* begin
        rd_mux = 32'h0000_0000;
        case (haddr)
            `IVA_OFS_CTRL:      rd_mux[1:0] = ctrl_reg;
            `IVA_OFS_SRC_EN:    rd_mux[N_SRC-1:0] = src_en_reg;
            `IVA_OFS_WAKE_EN:   rd_mux[N_WAKE-1:0] = wake_en_reg;
            `IVA_OFS_WAKE_EDGE: rd_mux[N_WAKE-1:0] = wake_edge_reg;
            `IVA_OFS_WAKE_PEND: rd_mux[N_WAKE-1:0] = wake_pend_reg;
            `IVA_OFS_STATUS: begin
                rd_mux[`IVA_STAT_OFS_MSB:`IVA_STAT_OFS_LSB] = last_ofs_reg;
                rd_mux[`IVA_STAT_IRQ]  = irq_req;
                rd_mux[`IVA_STAT_BUSY] = ~state_reg[0];
            end
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // address phase capture and read data for the following data phase
    always @(posedge ref_clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= `IVA_HRESP_OKAY;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr;
            end
            if (addr_phase & ~hwrite) begin
                hrdata <= rd_mux;
            end
            hreadyout <= 1'b1;
            hresp     <= `IVA_HRESP_OKAY;
        end
    end

    // ***********************************************************************
    // configuration registers
    // ***********************************************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl_reg      <= `IVA_CTRL_RESET;
            src_en_reg    <= {N_SRC{1'b0}};
            wake_en_reg   <= {N_WAKE{1'b0}};
            wake_edge_reg <= {N_WAKE{1'b0}};
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= hwdata[1:0];
            end
            // hardware wins over a software write in the same cycle
            if (mask_take) begin
                ctrl_reg[`IVA_CTRL_GIE] <= 1'b0;
            end else if (ret_exec & ret_is_return_from_irq_instr & ~trap_take) begin
                ctrl_reg[`IVA_CTRL_GIE] <= 1'b1;
            end
            if (do_write & (wr_addr_reg == `IVA_OFS_SRC_EN)) begin
                src_en_reg <= hwdata[N_SRC-1:0];
            end
            if (do_write & (wr_addr_reg == `IVA_OFS_WAKE_EN)) begin
                wake_en_reg <= hwdata[N_WAKE-1:0];
            end
            if (do_write & (wr_addr_reg == `IVA_OFS_WAKE_EDGE)) begin
                wake_edge_reg <= hwdata[N_WAKE-1:0];
            end
        end
    end

    // ***********************************************************************
    // wake pending: write one to clear, a new edge wins
    // ***********************************************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            portl_prev_reg <= portl_in;         // no false edge at release
            wake_pend_reg  <= {N_WAKE{1'b0}};
            wake_req       <= 1'b0;
        end else begin
            portl_prev_reg <= portl_in;
            wake_pend_reg  <= (wake_pend_reg &
                ~(wr_pend_w1c ? hwdata[N_WAKE-1:0] : {N_WAKE{1'b0}}))
                | wake_hit;
            // wake needs only low power and the pin enable; whether the routine runs
            // first is decided by irq_req at the next boundary
            wake_req <= low_power & (|(wake_hit & wake_en_reg));
        end
    end

    // ***********************************************************************
    // trap pending flag
    // ***********************************************************************
    // a trap in the same cycle as the clear keeps the flag set
    always @(posedge ref_clk) begin
        if (rst) begin
            trap_pending_flag <= 1'b0;
        end else if (trap_take) begin
            trap_pending_flag <= 1'b1;
        end else if (clear_trap_pending_instr_exec) begin
            trap_pending_flag <= 1'b0;
        end
    end

    // ***********************************************************************
    // instruction register and request level
    // ***********************************************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            instr_out   <= `IVA_TRAP_OPCODE;
            instr_valid <= 1'b0;
            irq_req     <= 1'b0;
        end else begin
            instr_valid <= fetch_valid;
            if (fetch_valid) begin
                instr_out <= fetch_data;
            end
            irq_req <= maskable_ok | trap_pending_flag;
        end
    end

    // ***********************************************************************
    // dispatch sequence and program counter control
    // ***********************************************************************
    // memory answers one cycle after vec_rd; the low byte is read while
    // the high byte returns, so a dispatch spends four cycles in all
    always @(posedge ref_clk) begin
        if (rst) begin
            state_reg    <= S_IDLE;
            vec_rd       <= 1'b0;
            vec_addr     <= 15'h0000;
            vec_hi_reg   <= 7'h00;
            last_ofs_reg <= `IVA_VEC_BASE;
            pc_load      <= 1'b0;
            pc_value     <= 15'h0000;
            push_req     <= 1'b0;
            push_addr    <= 15'h0000;
        end else begin
            vec_rd   <= 1'b0;
            pc_load  <= 1'b0;
            push_req <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (vis_exec & ~trap_take) begin
                        // sampled in the first dispatch cycle only
                        last_ofs_reg <= win_ofs;
                        vec_addr <= {vis_pc[14:8], win_ofs};
                        vec_rd   <= 1'b1;
                        state_reg <= S_HI;
                    end
                end
                S_HI: begin
                    vec_addr  <= vec_addr + 15'h0001;
                    vec_rd    <= 1'b1;
                    state_reg <= S_LO;
                end
                S_LO: begin
                    vec_hi_reg <= vec_rdata[6:0];
                    state_reg  <= S_DONE;
                end
                S_DONE: begin
                    pc_load   <= 1'b1;
                    pc_value  <= {vec_hi_reg, vec_rdata};
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
            if (trap_take) begin
                // return address is the trap opcode itself
                push_req  <= 1'b1;
                push_addr <= fetch_addr;
                pc_load   <= 1'b1;
                pc_value  <= `IVA_ENTRY_ADDR;
                state_reg <= S_IDLE;
            end else if (state_reg[0] & mask_take) begin
                push_req  <= 1'b1;
                push_addr <= next_pc;
                pc_load   <= 1'b1;
                pc_value  <= `IVA_ENTRY_ADDR;
            end else if (state_reg[0] & ret_exec & ~vis_exec) begin
                pc_load <= 1'b1;
                if (stack_ptr > `IVA_STACK_LIMIT) begin
                    pc_value <= `IVA_UNDERFLOW_PC;
                end else begin
                    pc_value <= ret_addr;
                end
            end
        end
    end
endmodule // iva_top

// >>> test/iva_mem_model.sv
`timescale 1ns/1ns
// ***********************************************************************
// iva_mem_model: program memory that answers the vector byte reads
// ***********************************************************************
module iva_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        vec_rd,
    input  wire logic [14:0] vec_addr,
    output logic      [7:0]  vec_rdata
);
    // byte comes one cycle after the read; between reads the data toggles,
    // so a sample one cycle late never meets a stale byte
    always @(posedge ref_clk) begin
        if (vec_rd)
            vec_rdata <= vec_addr[7:0] ^ {1'b0, vec_addr[14:8]} ^ 8'hA5;
        else
            vec_rdata <= ~vec_rdata;
    end

    // known start, otherwise the toggling would keep an unknown forever
    initial vec_rdata = 8'h00;
endmodule // iva_mem_model

// >>> test/iva_top_asserts.sv
`timescale 1ns/1ns
// ***********************************************************************
// iva_chk: timing of the arbiter's answers at its ports
// ***********************************************************************
module iva_chk #(
    parameter MEM_BYTES = 2048
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [14:0] vis_pc,
    input wire logic        ret_exec,
    input wire logic [14:0] ret_addr,
    input wire logic [7:0]  stack_ptr,
    input wire logic        instr_boundary,
    input wire logic        fetch_valid,
    input wire logic [14:0] fetch_addr,
    input wire logic [7:0]  fetch_raw,
    input wire logic [7:0]  vec_rdata,
    input wire logic        low_power,
    input wire logic [7:0]  instr_out,
    input wire logic        instr_valid,
    input wire logic        pc_load,
    input wire logic [14:0] pc_value,
    input wire logic        push_req,
    input wire logic [14:0] push_addr,
    input wire logic        vec_rd,
    input wire logic [14:0] vec_addr,
    input wire logic        irq_req,
    input wire logic        wake_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // a trap fetch: zero opcode, or any byte beyond the memory
    sequence trap_fetch_s;
        fetch_valid && (fetch_raw == 8'h00 || fetch_addr >= MEM_BYTES);
    endsequence
    // first of the two vector byte reads of a dispatch
    sequence disp_start_s;
        vec_rd && !$past(vec_rd);
    endsequence

    trap_push_a: assert property (
        trap_fetch_s |=> push_req && push_addr == $past(fetch_addr))
        else $error("trap pushed a wrong address");
    trap_irq_a: assert property (
        trap_fetch_s |-> ##[1:2] irq_req)
        else $error("trap left no request up");
    fetch_gate_a: assert property (
        fetch_valid && fetch_addr >= MEM_BYTES |=>
        instr_valid && instr_out == 8'h00)
        else $error("fetch beyond memory not zero");
    vec_even_a: assert property (
        disp_start_s |-> !vec_addr[0] && vec_addr[7:5] == 3'b111)
        else $error("vector offset out of range");
    vec_page_a: assert property (
        disp_start_s |-> vec_addr[14:8] == $past(vis_pc[14:8]))
        else $error("vector page changed");
    vec_load_a: assert property (
        disp_start_s |-> ##3 pc_load &&
        pc_value == {$past(vec_rdata[6:0], 2), $past(vec_rdata, 1)})
        else $error("vector not loaded high byte first");
    underflow_pc_a: assert property (
        ret_exec && !fetch_valid && !instr_boundary && !vec_rd &&
        stack_ptr > 8'h6F |=> pc_load && pc_value == 15'h7FFF)
        else $error("underflow did not load top address");
    ret_load_a: assert property (
        ret_exec && !fetch_valid && !instr_boundary && !vec_rd &&
        stack_ptr <= 8'h6F |=> pc_load && pc_value == $past(ret_addr))
        else $error("return did not load popped address");
    wake_low_a: assert property (
        wake_req |-> $past(low_power))
        else $error("wake outside low power");
endmodule // iva_chk

bind iva_top iva_chk #(.MEM_BYTES(MEM_BYTES)) iva_chk_i (.*);

// >>> test/iva_top_tb.sv
`timescale 1ns/1ns
`include "iva_regs.vh"
// ***********************************************************************
// iva_top_tb: register, dispatch, trap and wake scenarios
// ***********************************************************************
module iva_top_tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel, hwrite, hready, vis_exec, clear_trap_pending_instr_exec, seen;
    logic        ret_exec, ret_is_return_from_irq_instr, instr_boundary, fetch_valid;
    logic        low_power, instr_valid, pc_load, push_req, vec_rd;
    logic        irq_req, wake_req, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  haddr, stack_ptr, fetch_raw, vec_rdata, portl_in, instr_out;
    logic [8:0]  src_pend;
    logic [14:0] vis_pc, ret_addr, next_pc, fetch_addr, pc_value;
    logic [14:0] push_addr, vec_addr;
    logic [31:0] hwdata, hrdata, rd;
    int          n_fail = 0;
    int          total_checks = 0;

    // clock and the single slave's ready fed back as the bus ready
    always #5 ref_clk = ~ref_clk;
    assign hready = hreadyout;

    iva_top #(.MEM_BYTES(2048), .N_SRC(9), .N_WAKE(8)) iva_top_i (.*);
    iva_mem_model iva_mem_model_i (.*);

    // ***********************************************************************
    // access tasks
    // ***********************************************************************
    function automatic logic [7:0] vbyte(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'hA5;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one single word transfer; wait states allowed, ready is polled
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsize  <= 3'b010;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask

    // drop the one-cycle requests, then stop where their answer stands
    task automatic settle;
        @(posedge ref_clk);
        {vis_exec, clear_trap_pending_instr_exec, ret_exec, instr_boundary, fetch_valid} <= '0;
        @(posedge ref_clk);
    endtask

    task automatic dispatch(input logic [7:0] ofs);
        logic [14:0] a;
        logic [7:0]  hi;
        int          n;
        a = {7'h03, ofs};
        hi = vbyte(a);
        @(posedge ref_clk);
        vis_exec <= 1'b1;
        vis_pc   <= 15'h0310;
        settle();
        n = 0;
        while (pc_load !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        chk("vector pc", {16'h0, 1'b1, hi[6:0], vbyte(a + 15'd1)},
            {pc_load, pc_value});
        ahb(1'b0, `IVA_OFS_STATUS, 32'h0000_0000);
        chk("offset", {24'h0, ofs}, {24'h0, rd[7:0]});
    endtask

    task automatic fetch(input logic [14:0] a, input logic [7:0] op);
        @(posedge ref_clk);
        fetch_valid <= 1'b1;
        fetch_addr  <= a;
        fetch_raw   <= op;
        settle();
    endtask

    task automatic take(input logic [14:0] npc);
        @(posedge ref_clk);
        instr_boundary <= 1'b1;
        next_pc        <= npc;
        settle();
    endtask

    task automatic retn(input logic return_from_irq_instr, input logic [7:0] sp);
        @(posedge ref_clk);
        ret_exec    <= 1'b1;
        ret_is_return_from_irq_instr <= return_from_irq_instr;
        ret_addr    <= 15'h0456;
        stack_ptr   <= sp;
        settle();
    endtask

    task automatic clear_trap_pending_instr_twice;
        repeat (2) begin
            @(posedge ref_clk);
            clear_trap_pending_instr_exec <= 1'b1;
            settle();
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ***********************************************************************
    // scenarios
    // ***********************************************************************
    initial begin
        {hsel, hwrite, vis_exec, clear_trap_pending_instr_exec, ret_exec, ret_is_return_from_irq_instr} = '0;
        {instr_boundary, fetch_valid, low_power, htrans, hsize} = '0;
        {haddr, stack_ptr, fetch_raw, src_pend, vis_pc, ret_addr} = '0;
        {next_pc, fetch_addr, hwdata, seen} = '0;
        portl_in = 8'h02;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk("ctrl", `IVA_OFS_CTRL, 32'h0000_0001);
        rd_chk("status", `IVA_OFS_STATUS, 32'h0000_00E0);
        dispatch(8'hE0);
        $display("test reset done");
        ahb(1'b1, `IVA_OFS_SRC_EN, 32'h0000_01FF);
        for (int i = 0; i < 9; i++) begin
            src_pend <= 9'h1FF << i;
            dispatch(8'hFA - 8'(2 * i));
        end
        ahb(1'b1, `IVA_OFS_SRC_EN, 32'h0000_0000);
        src_pend <= 9'h1FF;
        dispatch(8'hE0);
        $display("test rank done");
        ahb(1'b1, `IVA_OFS_WAKE_EN, 32'h0000_00FF);
        ahb(1'b1, `IVA_OFS_WAKE_EDGE, 32'h0000_0002);
        portl_in <= 8'h04;
        rd_chk("wake pend", `IVA_OFS_WAKE_PEND, 32'h0000_0006);
        chk("irq off", 32'h0, {31'h0, irq_req});
        ahb(1'b1, `IVA_OFS_CTRL, 32'h0000_0003);
        repeat (2) @(posedge ref_clk);
        chk("irq on", 32'h1, {31'h0, irq_req});
        dispatch(8'hE2);
        $display("test port done");
        take(15'h0123);
        chk("take push", 32'h0000_8123, {push_req, push_addr});
        chk("take pc", 32'h0000_80FF, {pc_load, pc_value});
        rd_chk("gie off", `IVA_OFS_CTRL, 32'h0000_0002);
        take(15'h0124);
        chk("nested", 32'h0, {31'h0, push_req});
        retn(1'b1, 8'h6E);
        chk("return_from_irq_instr pc", 32'h0000_8456, {pc_load, pc_value});
        rd_chk("gie on", `IVA_OFS_CTRL, 32'h0000_0003);
        $display("test take done");
        fetch(15'h0100, 8'h3C);
        chk("plain op", 32'h0000_003C, {push_req, instr_out});
        fetch(15'h0234, 8'h00);
        chk("trap push", 32'h0000_8234, {push_req, push_addr});
        chk("trap pc", 32'h0000_80FF, {pc_load, pc_value});
        rd_chk("gie kept", `IVA_OFS_CTRL, 32'h0000_0003);
        rd_chk("no flag", 8'h18, 32'h0000_0000);
        ahb(1'b1, `IVA_OFS_SRC_EN, 32'h0000_01FF);
        dispatch(8'hFE);
        take(15'h0200);
        chk("trap blocks", 32'h0, {31'h0, push_req});
        clear_trap_pending_instr_twice();
        dispatch(8'hFA);
        $display("test trap done");
        retn(1'b0, 8'h70);
        chk("underflow pc", 32'h0000_FFFF, {pc_load, pc_value});
        fetch(15'h7FFF, 8'h3C);
        chk("gated op", 32'h0000_0100, {instr_valid, instr_out});
        chk("gap trap", 32'h0000_FFFF, {push_req, push_addr});
        clear_trap_pending_instr_twice();
        $display("test underflow done");
        ahb(1'b1, `IVA_OFS_WAKE_PEND, 32'h0000_00FF);
        rd_chk("pend clear", `IVA_OFS_WAKE_PEND, 32'h0000_0000);
        low_power <= 1'b1;
        portl_in  <= 8'h24;
        repeat (4) begin
            @(posedge ref_clk);
            if (wake_req === 1'b1)
                seen = 1'b1;
        end
        chk("wake", 32'h1, {31'h0, seen});
        low_power <= 1'b0;
        $display("test wake done");
        complete_run();
    end

    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        #100000;
        n_fail++;
        $display("unexpected watchdog: expected finish seen hang");
        complete_run();
    end
endmodule // iva_top_tb
